// File: frp_pkg.sv
// Constants and types shared by the flash read-protection level block
package frp_pkg;

  // Protection byte patterns
  localparam logic [7:0] OPEN_BYTE = 8'ha5;
  localparam logic [7:0] OPEN_COMPL = 8'h5a;
  localparam logic [7:0] TWO_BYTE = 8'hcc;
  localparam logic [7:0] TWO_COMPL = 8'h33;
  localparam logic [7:0] ERASED_BYTE = 8'hff;

  // Option unlock keys, first then second
  localparam logic [31:0] KEY_FIRST = 32'h45670123;
  localparam logic [31:0] KEY_SECOND = 32'hcdef89ab;

  // Register byte offsets
  localparam logic [7:0] ADDR_KEY = 8'h00;
  localparam logic [7:0] ADDR_CTRL = 8'h04;
  localparam logic [7:0] ADDR_OPTPROG = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;

  // Field positions
  localparam int CTRL_OPT_EN_BIT = 0;
  localparam int CTRL_OPT_ERASE_BIT = 1;
  localparam int PROG_ONE_LSB = 0;
  localparam int PROG_TWO_LSB = 16;
  localparam int ST_UNLOCKED_BIT = 2;
  localparam int ST_KEY_DEAD_BIT = 3;
  localparam int ST_PROT_ERR_BIT = 4;
  localparam int ST_AUTO_BUSY_BIT = 5;
  localparam int ST_DECODED_BIT = 6;

  // Page pair that level one protects on its own (pages 0 and 1)
  localparam logic [4:0] AUTO_WP_PAIR = 5'h00;
  localparam logic [3:0] FULL_STRB = 4'hf;

  typedef enum logic [1:0] {OPEN_LEVEL, LEVEL_ONE, LEVEL_TWO} frp_level_type;
  typedef enum logic [1:0] {MST_CPU, MST_DMA, MST_DEBUG} frp_master_type;
  typedef enum logic [1:0] {OP_READ, OP_PROGRAM, OP_PAGE_ERASE, OP_MASS_ERASE} frp_op_type;
  typedef enum logic [1:0] {RG_MAIN, RG_OPTION, RG_SYSTEM, RG_SRAM} frp_region_type;
  typedef enum logic [1:0] {BOOT_MAIN, BOOT_SYSTEM, BOOT_SRAM} frp_boot_type;

  // Values after reset
  localparam frp_level_type RESET_LEVEL = LEVEL_ONE;
  localparam logic [31:0] RESET_WORD = 32'h00000000;

  typedef struct packed {
    logic [7:0] level_two_protect_complement;
    logic [7:0] level_two_protect_byte;
    logic [7:0] level_one_protect_complement;
    logic [7:0] level_one_protect_byte;
  } frp_opt_type;

  typedef struct packed {
    logic valid;
    frp_master_type master;
    frp_op_type op;
    frp_region_type region;
    logic [5:0] page;
  } frp_access_type;

  typedef struct packed {
    logic grant;
    logic refuse;
  } frp_resp_type;

endpackage

// File: frp_flash_read_protect.sv
// Flash read-protection level decode, access gating and level change control
//
// Overview of operation
// - Open level only for A5/5A level-one pair and no level-two pattern.
// - Level-two byte CC with complement 33 decodes level two, whatever level-one holds.
// - Every other combination, erased FF included, decodes as level one.
// - At open level any master reads main flash and option area freely.
// - At open level page program and erase follow only page write protection.
// - At level one main reads only from main-flash boot without debugger.
// - At level one pages 0 and 1 are always write-protected.
// - At level one main-flash code may program and erase unprotected pages.
// - At level one debug or SRAM boot refuses page program/erase, not mass erase.
// - At level one debug may still load and run code in SRAM.
// - Back to open: unlock, erase option area, write A5; device mass-erases, rewrites A5.
// - Erasing option area alone never starts the automatic mass erase.
// - New protection value only takes effect after reset reloads option bytes.
// - At level one code booted from SRAM, DMA included, cannot read, program or page-erase main flash.
// - At level one debug cannot read, program or page-erase main flash.
// - Level two bars SRAM boot, debug, option writes and any level change.
// - From open level a change to level one or two is accepted.
// - From level one a change to open or two is accepted; open mass-erases only after an option erase.
// - Mass erase of main flash is accepted whenever the access path is enabled.
// - System memory only from system-memory boot, never from other boots or debug.
//
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module frp_flash_read_protect (
  // Clock and reset
  input logic pclk,
  input logic presetn,
  // APB slave
  input logic [7:0] paddr,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [31:0] pwdata,
  input logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Option image from flash, boot source and debug state
  input frp_pkg::frp_opt_type opt_image,
  input frp_pkg::frp_boot_type boot_src,
  input logic debug_attached,
  input logic [31:0] page_wp,
  // Access check for bus masters
  input frp_pkg::frp_access_type acc_req,
  output frp_pkg::frp_resp_type acc_resp,
  // Flash program/erase controller
  output logic opt_erase_req,
  output logic opt_prog_req,
  output frp_pkg::frp_opt_type opt_prog_data,
  output logic mass_erase_req,
  input logic mass_erase_done,
  // Decoded level
  output frp_pkg::frp_level_type level
);

  typedef enum logic [1:0] {KEY_LOCKED, KEY_HALF, KEY_OPEN, KEY_DEAD} frp_key_state_type;
  typedef enum logic {AE_IDLE, AE_ERASE} frp_ae_state_type;

  frp_pkg::frp_opt_type opt_cap;
  frp_pkg::frp_opt_type new_image;
  frp_key_state_type key_state;
  frp_ae_state_type ae_state;
  logic loaded;
  logic decoded;
  logic erased_seen;
  logic prot_err;
  logic permit;
  logic dbg;
  logic wp_hit;
  logic two_blocked;
  logic opt_ok;
  logic err;
  logic [31:0] rdata;
  logic cap_two;

  // Level decode of one option image
  function automatic frp_pkg::frp_level_type decode_level(input frp_pkg::frp_opt_type o);
    logic two;
    logic open;
    two = (o.level_two_protect_byte == frp_pkg::TWO_BYTE) &&
          (o.level_two_protect_complement == frp_pkg::TWO_COMPL);
    open = (o.level_one_protect_byte == frp_pkg::OPEN_BYTE) &&
           (o.level_one_protect_complement == frp_pkg::OPEN_COMPL) && !two;
    if (two) begin
      decode_level = frp_pkg::LEVEL_TWO;
    end else if (open) begin
      decode_level = frp_pkg::OPEN_LEVEL;
    end else begin
      decode_level = frp_pkg::LEVEL_ONE;
    end
  endfunction

  // Catch the option image once, the first edge after reset release
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loaded <= 1'b0;
      opt_cap <= frp_pkg::RESET_WORD;
    end else if (!loaded) begin
      opt_cap <= opt_image;
      loaded <= 1'b1;
    end
  end

  // Level is decoded once per reset; later option writes wait for the next reload
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= frp_pkg::RESET_LEVEL;
      decoded <= 1'b0;
    end else if (loaded && !decoded) begin
      level <= decode_level(opt_cap);
      decoded <= 1'b1;
    end
  end

  assign cap_two = (opt_cap.level_two_protect_byte == frp_pkg::TWO_BYTE) &&
                   (opt_cap.level_two_protect_complement == frp_pkg::TWO_COMPL);

  // Access permission; until decode ends the level reads as level one, the safe side
  always_comb begin
    dbg = debug_attached || (acc_req.master == frp_pkg::MST_DEBUG);
    two_blocked = (level == frp_pkg::LEVEL_TWO) && (dbg || boot_src == frp_pkg::BOOT_SRAM);
    wp_hit = page_wp[acc_req.page[5:1]] ||
             ((level != frp_pkg::OPEN_LEVEL) && (acc_req.page[5:1] == frp_pkg::AUTO_WP_PAIR));
    permit = 1'b0;
    case (acc_req.region)
      frp_pkg::RG_MAIN: begin
        case (acc_req.op)
          frp_pkg::OP_READ: begin
            // Open reads freely; otherwise only main-boot code, no debug, no SRAM boot
            permit = (level == frp_pkg::OPEN_LEVEL) ||
                     (boot_src == frp_pkg::BOOT_MAIN && !dbg);
          end
          frp_pkg::OP_PROGRAM, frp_pkg::OP_PAGE_ERASE: begin
            permit = !wp_hit && ((level == frp_pkg::OPEN_LEVEL) ||
                     !(dbg || boot_src == frp_pkg::BOOT_SRAM));
          end
          frp_pkg::OP_MASS_ERASE: begin
            permit = 1'b1;
          end
          default: begin
            permit = 1'b0;
          end
        endcase
        // Main array is off limits while the automatic erase runs
        if (ae_state != AE_IDLE) begin
          permit = 1'b0;
        end
      end
      frp_pkg::RG_OPTION: begin
        if (acc_req.op == frp_pkg::OP_READ) begin
          permit = 1'b1;
        end else begin
          permit = (acc_req.op != frp_pkg::OP_MASS_ERASE) && (level != frp_pkg::LEVEL_TWO);
        end
      end
      frp_pkg::RG_SYSTEM: begin
        permit = (boot_src == frp_pkg::BOOT_SYSTEM) && !dbg &&
                 (acc_req.op != frp_pkg::OP_MASS_ERASE);
      end
      frp_pkg::RG_SRAM: begin
        permit = 1'b1;
      end
      default: begin
        permit = 1'b0;
      end
    endcase
    if (two_blocked) begin
      permit = 1'b0;
    end
  end

  // Registered answer, one cycle after the request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_resp <= '0;
    end else begin
      acc_resp.grant <= acc_req.valid && decoded && permit;
      acc_resp.refuse <= acc_req.valid && !(decoded && permit);
    end
  end

  // New option image from a program write; complements made by hardware
  always_comb begin
    new_image.level_one_protect_byte = pwdata[frp_pkg::PROG_ONE_LSB +: 8];
    new_image.level_one_protect_complement = ~pwdata[frp_pkg::PROG_ONE_LSB +: 8];
    new_image.level_two_protect_byte = pwdata[frp_pkg::PROG_TWO_LSB +: 8];
    new_image.level_two_protect_complement = ~pwdata[frp_pkg::PROG_TWO_LSB +: 8];
  end

  // Option area writable only after unlock, never at level two
  assign opt_ok = (key_state == KEY_OPEN) && (level != frp_pkg::LEVEL_TWO) &&
                  (ae_state == AE_IDLE) && decoded;

  // Error decode in the first access cycle
  always_comb begin
    err = 1'b0;
    case (paddr)
      frp_pkg::ADDR_KEY: begin
        if (pwrite) begin
          err = (pstrb != frp_pkg::FULL_STRB) || (key_state == KEY_DEAD) ||
                (key_state == KEY_LOCKED && pwdata != frp_pkg::KEY_FIRST) ||
                (key_state == KEY_HALF && pwdata != frp_pkg::KEY_SECOND);
        end
      end
      frp_pkg::ADDR_CTRL: begin
        err = pwrite && pwdata[frp_pkg::CTRL_OPT_ERASE_BIT] && !opt_ok;
      end
      frp_pkg::ADDR_OPTPROG: begin
        err = pwrite && !opt_ok;
      end
      frp_pkg::ADDR_STATUS: begin
        err = 1'b0;
      end
      default: begin
        err = 1'b1;
      end
    endcase
  end

  // Read mux
  always_comb begin
    rdata = frp_pkg::RESET_WORD;
    case (paddr)
      frp_pkg::ADDR_CTRL: begin
        rdata[frp_pkg::CTRL_OPT_EN_BIT] = (key_state == KEY_OPEN);
      end
      frp_pkg::ADDR_OPTPROG: begin
        rdata = opt_cap;
      end
      frp_pkg::ADDR_STATUS: begin
        rdata[1:0] = level;
        rdata[frp_pkg::ST_UNLOCKED_BIT] = (key_state == KEY_OPEN);
        rdata[frp_pkg::ST_KEY_DEAD_BIT] = (key_state == KEY_DEAD);
        rdata[frp_pkg::ST_PROT_ERR_BIT] = prot_err;
        rdata[frp_pkg::ST_AUTO_BUSY_BIT] = (ae_state != AE_IDLE);
        rdata[frp_pkg::ST_DECODED_BIT] = decoded;
      end
      default: begin
        rdata = frp_pkg::RESET_WORD;
      end
    endcase
  end

  // APB answer: one wait state, so every output comes from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= frp_pkg::RESET_WORD;
    end else begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && err;
      prdata <= (psel && penable && !pready && !pwrite) ? rdata : frp_pkg::RESET_WORD;
    end
  end

  logic fire;
  logic wr_ok;
  assign fire = psel && penable && pready && pwrite;
  assign wr_ok = fire && !pslverr;

  // Unlock sequence; a bad key or order stays dead until reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      key_state <= KEY_LOCKED;
    end else if (fire && paddr == frp_pkg::ADDR_KEY) begin
      case (key_state)
        KEY_LOCKED: key_state <= pslverr ? KEY_DEAD : KEY_HALF;
        KEY_HALF: key_state <= pslverr ? KEY_DEAD : KEY_OPEN;
        KEY_OPEN: key_state <= KEY_OPEN;
        KEY_DEAD: key_state <= KEY_DEAD;
        default: key_state <= KEY_DEAD;
      endcase
    end else if (wr_ok && paddr == frp_pkg::ADDR_CTRL && !pwdata[frp_pkg::CTRL_OPT_EN_BIT] &&
                 key_state == KEY_OPEN) begin
      key_state <= KEY_LOCKED;
    end
  end

  // Option erase, option program and the automatic mass erase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opt_erase_req <= 1'b0;
      opt_prog_req <= 1'b0;
      mass_erase_req <= 1'b0;
      opt_prog_data <= frp_pkg::RESET_WORD;
      erased_seen <= 1'b0;
      ae_state <= AE_IDLE;
    end else begin
      opt_erase_req <= 1'b0;
      opt_prog_req <= 1'b0;
      mass_erase_req <= 1'b0;
      case (ae_state)
        AE_IDLE: begin
          if (wr_ok && paddr == frp_pkg::ADDR_CTRL && pwdata[frp_pkg::CTRL_OPT_ERASE_BIT]) begin
            // Erase alone leaves FF, still level one, so no array erase here
            opt_erase_req <= 1'b1;
            erased_seen <= 1'b1;
          end else if (wr_ok && paddr == frp_pkg::ADDR_OPTPROG) begin
            opt_prog_data <= new_image;
            if (level == frp_pkg::LEVEL_ONE && erased_seen &&
                decode_level(new_image) == frp_pkg::OPEN_LEVEL) begin
              mass_erase_req <= 1'b1;
              ae_state <= AE_ERASE;
            end else begin
              opt_prog_req <= 1'b1;
            end
          end
        end
        AE_ERASE: begin
          // Array gone: now store the open pattern held in opt_prog_data
          if (mass_erase_done) begin
            opt_prog_req <= 1'b1;
            ae_state <= AE_IDLE;
          end
        end
        default: begin
          ae_state <= AE_IDLE;
        end
      endcase
    end
  end

  // Sticky protection error; a new event beats a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prot_err <= 1'b0;
    end else if (acc_resp.refuse || (pslverr && pready)) begin
      prot_err <= 1'b1;
    end else if (wr_ok && paddr == frp_pkg::ADDR_STATUS && pwdata[frp_pkg::ST_PROT_ERR_BIT]) begin
      prot_err <= 1'b0;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_OPEN_DECODE: assert property (decoded && level == frp_pkg::OPEN_LEVEL |->
    opt_cap.level_one_protect_byte == frp_pkg::OPEN_BYTE &&
    opt_cap.level_one_protect_complement == frp_pkg::OPEN_COMPL && !cap_two)
    else $error("open level without open pattern");
  AST_TWO_DECODE: assert property (decoded && cap_two |-> level == frp_pkg::LEVEL_TWO)
    else $error("level two pattern not decoded");
  AST_ERASED_ONE: assert property (decoded && !cap_two &&
    opt_cap.level_one_protect_byte == frp_pkg::ERASED_BYTE |-> level == frp_pkg::LEVEL_ONE)
    else $error("erased bytes not level one");
  AST_LEVEL_HELD: assert property (decoded && $past(decoded) |-> $stable(level))
    else $error("level changed without reset");
  AST_OPEN_READ: assert property (acc_req.valid && decoded && level == frp_pkg::OPEN_LEVEL &&
    acc_req.region == frp_pkg::RG_MAIN && acc_req.op == frp_pkg::OP_READ && ae_state == AE_IDLE
    |=> acc_resp.grant) else $error("open read refused");
  AST_DEBUG_READ: assert property (acc_req.valid && level != frp_pkg::OPEN_LEVEL &&
    acc_req.region == frp_pkg::RG_MAIN && acc_req.op == frp_pkg::OP_READ &&
    (debug_attached || acc_req.master == frp_pkg::MST_DEBUG) |=> acc_resp.refuse)
    else $error("protected read by debug granted");
  AST_AUTO_WP: assert property (acc_req.valid && level != frp_pkg::OPEN_LEVEL &&
    acc_req.region == frp_pkg::RG_MAIN && acc_req.op == frp_pkg::OP_PROGRAM &&
    acc_req.page[5:1] == frp_pkg::AUTO_WP_PAIR |=> acc_resp.refuse)
    else $error("pages 0 and 1 programmed at level one");
  AST_SRAM_BOOT: assert property (acc_req.valid && level != frp_pkg::OPEN_LEVEL &&
    boot_src == frp_pkg::BOOT_SRAM && acc_req.region == frp_pkg::RG_MAIN &&
    acc_req.op != frp_pkg::OP_MASS_ERASE |=> acc_resp.refuse)
    else $error("sram boot reached main flash");
  AST_MASS_OK: assert property (acc_req.valid && decoded && level != frp_pkg::LEVEL_TWO &&
    acc_req.region == frp_pkg::RG_MAIN && acc_req.op == frp_pkg::OP_MASS_ERASE &&
    ae_state == AE_IDLE |=> acc_resp.grant) else $error("mass erase refused");
  AST_SYSMEM: assert property (acc_req.valid && acc_req.region == frp_pkg::RG_SYSTEM &&
    boot_src != frp_pkg::BOOT_SYSTEM |=> acc_resp.refuse) else $error("system memory reached");
  AST_L2_FROZEN: assert property (level == frp_pkg::LEVEL_TWO |->
    !opt_prog_req && !opt_erase_req && !mass_erase_req) else $error("level two modified");
  AST_AUTO_REWRITE: assert property (ae_state == AE_ERASE && mass_erase_done |=>
    opt_prog_req && opt_prog_data.level_one_protect_byte == frp_pkg::OPEN_BYTE ##1 !opt_prog_req)
    else $error("open pattern not rewritten after mass erase");
  AST_ERASE_ALONE: assert property (opt_erase_req |-> !mass_erase_req ##1 !mass_erase_req)
    else $error("option erase started mass erase");
  AST_ERR_FLAG: assert property (acc_resp.refuse |=> prot_err)
    else $error("refusal without error flag");

  COV_AUTO_ERASE: cover property (ae_state == AE_ERASE ##[1:50] opt_prog_req);
  COV_UNLOCK: cover property (key_state == KEY_HALF ##[1:10] key_state == KEY_OPEN);
  COV_TWO_GRANT: cover property (level == frp_pkg::LEVEL_TWO && acc_resp.grant);

endmodule

// File: frp_flash_model.sv
// Flash controller stand-in: option image store and main flash mass erase
`timescale 1ns/1ps
module frp_flash_model #(
  parameter int DONE_DELAY = 6
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Requests from the protection block
  input wire logic opt_erase_req,
  input wire logic opt_prog_req,
  input frp_pkg::frp_opt_type opt_prog_data,
  input wire logic mass_erase_req,
  // Answers to the protection block
  output logic mass_erase_done,
  output frp_pkg::frp_opt_type opt_image
);
  int wait_cnt = 0;
  logic main_erased = 1'b0;

  // Option cells keep their value across reset, like real flash
  initial begin
    opt_image = 32'hffffffff;
  end

  // Option area erase and program; plain always so the bench may preload cells
  always @(posedge pclk) begin
    if (opt_erase_req === 1'b1) begin
      opt_image <= 32'hffffffff;
    end else if (opt_prog_req === 1'b1) begin
      opt_image <= opt_prog_data;
    end
  end

  // Mass erase is slow on purpose; done is a single pulse, low otherwise
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt <= 0;
      mass_erase_done <= 1'b0;
    end else begin
      mass_erase_done <= 1'b0;
      if (mass_erase_req === 1'b1) begin
        wait_cnt <= DONE_DELAY;
      end else if (wait_cnt == 1) begin
        wait_cnt <= 0;
        mass_erase_done <= 1'b1;
        main_erased <= 1'b1;
      end else if (wait_cnt > 1) begin
        wait_cnt <= wait_cnt - 1;
      end
    end
  end
endmodule

// File: tb_flash_read_protection_levels.sv
// Self-checking bench for the flash read-protection level block
`timescale 1ns/1ps
module tb_flash_read_protection_levels;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  logic pready;
  logic [31:0] prdata;
  logic pslverr;
  frp_pkg::frp_opt_type opt_image;
  frp_pkg::frp_boot_type boot_src = frp_pkg::BOOT_MAIN;
  logic debug_attached = 1'b0;
  logic [31:0] page_wp = 32'h0;
  frp_pkg::frp_access_type acc_req = '0;
  frp_pkg::frp_resp_type acc_resp;
  logic opt_erase_req;
  logic opt_prog_req;
  frp_pkg::frp_opt_type opt_prog_data;
  logic mass_erase_req;
  logic mass_erase_done;
  frp_pkg::frp_level_type level;
  int bad_count = 0;
  int num_checks = 0;
  int me_count = 0;
  logic [31:0] rd;
  logic err;
  logic [31:0] img_tab [9] = '{32'hffff5aa5, 32'h00cc5aa5, 32'h5aa55aa5, 32'h33cc5aa5, 32'h33ccffff,
                               32'h33cc1234, 32'hffffffff, 32'hffff5a5a, 32'hffff00a5};
  logic [1:0] lv_tab [9] = '{2'd0, 2'd0, 2'd0, 2'd2, 2'd2, 2'd2, 2'd1, 2'd1, 2'd1};

  frp_flash_read_protect dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .opt_image(opt_image), .boot_src(boot_src), .debug_attached(debug_attached), .page_wp(page_wp),
    .acc_req(acc_req), .acc_resp(acc_resp), .opt_erase_req(opt_erase_req), .opt_prog_req(opt_prog_req),
    .opt_prog_data(opt_prog_data), .mass_erase_req(mass_erase_req), .mass_erase_done(mass_erase_done),
    .level(level));

  frp_flash_model flash (.pclk(pclk), .presetn(presetn), .opt_erase_req(opt_erase_req),
    .opt_prog_req(opt_prog_req), .opt_prog_data(opt_prog_data), .mass_erase_req(mass_erase_req),
    .mass_erase_done(mass_erase_done), .opt_image(opt_image));

  // 250 MHz clock
  initial begin
    forever #2 pclk = ~pclk;
  end

  // Count automatic mass erase requests
  always @(posedge pclk) begin
    if (mass_erase_req === 1'b1) begin
      me_count <= me_count + 1;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No cycle count assumed; only the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // One access check; the answer is read at the edge after the one that launched it
  task automatic acc(input frp_pkg::frp_master_type m, input frp_pkg::frp_op_type o,
                     input frp_pkg::frp_region_type r, input logic [5:0] pg, input logic g);
    @(posedge pclk);
    acc_req <= '{1'b1, m, o, r, pg};
    @(posedge pclk);
    acc_req.valid <= 1'b0;
    @(posedge pclk);
    chk({30'h0, acc_resp}, {30'h0, g, ~g});
  endtask

  // Reset, optionally preloading the option cells, then wait past the decode
  task automatic rst(input logic load, input logic [31:0] img);
    @(posedge pclk);
    presetn <= 1'b0;
    if (load) begin
      flash.opt_image <= img;
    end
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
  endtask

  task automatic unlock;
    apb(1'b1, frp_pkg::ADDR_KEY, frp_pkg::KEY_FIRST);
    apb(1'b1, frp_pkg::ADDR_KEY, frp_pkg::KEY_SECOND);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Watchdog sized well beyond the few hundred cycles the tests need
  initial begin
    #200000;
    bad_count++;
    give_verdict();
  end

  // Main sequence
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk({30'h0, level}, 32'h1);
    for (int i = 0; i < 9; i++) begin
      rst(1'b1, img_tab[i]);
      chk({30'h0, level}, {30'h0, lv_tab[i]});
    end
    // Open level: free reads, page protection only from page_wp
    rst(1'b1, 32'hffff5aa5);
    page_wp <= 32'h2;
    acc(frp_pkg::MST_DEBUG, frp_pkg::OP_READ, frp_pkg::RG_MAIN, 6'd4, 1'b1);
    acc(frp_pkg::MST_DMA, frp_pkg::OP_READ, frp_pkg::RG_OPTION, 6'd0, 1'b1);
    acc(frp_pkg::MST_CPU, frp_pkg::OP_PROGRAM, frp_pkg::RG_MAIN, 6'd0, 1'b1);
    acc(frp_pkg::MST_CPU, frp_pkg::OP_PAGE_ERASE, frp_pkg::RG_MAIN, 6'd3, 1'b0);
    acc(frp_pkg::MST_DEBUG, frp_pkg::OP_READ, frp_pkg::RG_SYSTEM, 6'd0, 1'b0);
    apb(1'b0, frp_pkg::ADDR_STATUS, 32'h0);
    chk({rd[6], rd[4], rd[1:0]}, 32'hc);
    apb(1'b1, frp_pkg::ADDR_KEY, frp_pkg::KEY_SECOND);
    chk(err, 1'b1);
    apb(1'b1, frp_pkg::ADDR_KEY, frp_pkg::KEY_FIRST);
    chk(err, 1'b1);
    apb(1'b0, frp_pkg::ADDR_STATUS, 32'h0);
    chk({rd[3], rd[2]}, 32'h2);
    apb(1'b0, 8'h10, 32'h0);
    chk(err, 1'b1);
    // Level one from a non-open image, so the option erase below shows up
    rst(1'b1, 32'hffff00ff);
    page_wp <= 32'h0;
    acc(frp_pkg::MST_CPU, frp_pkg::OP_READ, frp_pkg::RG_MAIN, 6'd4, 1'b1);
    acc(frp_pkg::MST_CPU, frp_pkg::OP_PROGRAM, frp_pkg::RG_MAIN, 6'd0, 1'b0);
    acc(frp_pkg::MST_CPU, frp_pkg::OP_PAGE_ERASE, frp_pkg::RG_MAIN, 6'd1, 1'b0);
    acc(frp_pkg::MST_CPU, frp_pkg::OP_PROGRAM, frp_pkg::RG_MAIN, 6'd5, 1'b1);
    acc(frp_pkg::MST_CPU, frp_pkg::OP_READ, frp_pkg::RG_SYSTEM, 6'd0, 1'b0);
    debug_attached <= 1'b1;
    acc(frp_pkg::MST_DEBUG, frp_pkg::OP_READ, frp_pkg::RG_MAIN, 6'd4, 1'b0);
    acc(frp_pkg::MST_CPU, frp_pkg::OP_PROGRAM, frp_pkg::RG_MAIN, 6'd5, 1'b0);
    acc(frp_pkg::MST_DEBUG, frp_pkg::OP_MASS_ERASE, frp_pkg::RG_MAIN, 6'd0, 1'b1);
    acc(frp_pkg::MST_DEBUG, frp_pkg::OP_PROGRAM, frp_pkg::RG_SRAM, 6'd0, 1'b1);
    debug_attached <= 1'b0;
    boot_src <= frp_pkg::BOOT_SRAM;
    acc(frp_pkg::MST_DMA, frp_pkg::OP_READ, frp_pkg::RG_MAIN, 6'd4, 1'b0);
    acc(frp_pkg::MST_CPU, frp_pkg::OP_PAGE_ERASE, frp_pkg::RG_MAIN, 6'd5, 1'b0);
    acc(frp_pkg::MST_CPU, frp_pkg::OP_READ, frp_pkg::RG_SRAM, 6'd0, 1'b1);
    boot_src <= frp_pkg::BOOT_SYSTEM;
    acc(frp_pkg::MST_CPU, frp_pkg::OP_READ, frp_pkg::RG_SYSTEM, 6'd0, 1'b1);
    boot_src <= frp_pkg::BOOT_MAIN;
    // Level one back to open: unlock, erase options, write A5
    unlock();
    apb(1'b0, frp_pkg::ADDR_STATUS, 32'h0);
    chk(rd[2], 1'b1);
    apb(1'b1, frp_pkg::ADDR_CTRL, 32'h3);
    repeat (10) @(posedge pclk);
    chk(me_count, 0);
    chk(opt_image, 32'hffffffff);
    apb(1'b1, frp_pkg::ADDR_OPTPROG, 32'h00ff00a5);
    repeat (20) @(posedge pclk);
    chk(me_count, 1);
    chk({flash.main_erased, opt_image[7:0]}, 32'h1a5);
    chk({30'h0, level}, 32'h1);
    rst(1'b0, 32'h0);
    chk({30'h0, level}, 32'h0);
    // Open to level two, no erase on the way
    unlock();
    apb(1'b1, frp_pkg::ADDR_OPTPROG, 32'h00cc00ff);
    repeat (10) @(posedge pclk);
    chk(me_count, 1);
    rst(1'b0, 32'h0);
    chk({30'h0, level}, 32'h2);
    acc(frp_pkg::MST_CPU, frp_pkg::OP_READ, frp_pkg::RG_MAIN, 6'd4, 1'b1);
    acc(frp_pkg::MST_CPU, frp_pkg::OP_PROGRAM, frp_pkg::RG_OPTION, 6'd0, 1'b0);
    debug_attached <= 1'b1;
    acc(frp_pkg::MST_DEBUG, frp_pkg::OP_READ, frp_pkg::RG_MAIN, 6'd4, 1'b0);
    debug_attached <= 1'b0;
    boot_src <= frp_pkg::BOOT_SRAM;
    acc(frp_pkg::MST_CPU, frp_pkg::OP_READ, frp_pkg::RG_SRAM, 6'd0, 1'b0);
    boot_src <= frp_pkg::BOOT_MAIN;
    unlock();
    apb(1'b1, frp_pkg::ADDR_CTRL, 32'h3);
    chk(err, 1'b1);
    apb(1'b1, frp_pkg::ADDR_OPTPROG, 32'h00ff00a5);
    chk(err, 1'b1);
    give_verdict();
  end
endmodule
